// File: hw/valid_defs.vh
`ifndef VALID_DEFS_VH
`define VALID_DEFS_VH

// register offsets
`define OFF_VALID_LOW   4'h0
`define OFF_VALID_HIGH  4'h1
`define OFF_IRQ_STATUS  4'h2
`define OFF_IRQ_MASK    4'h3

// alarm word layout per input: soft freq, hard freq, no activity, phase lock
`define ALM_SOFT        0
`define ALM_HARD        1
`define ALM_ACT         2
`define ALM_LOCK        3
`define ALM_W           4

// reset values
`define VALID_RST       8'h00
`define MASK_RST        8'h00
`define HIGH_USED       6

`endif

// File: hw/valid_eval.v
`include "valid_defs.vh"

// combinational validity judge for a packed array of alarm words
module valid_eval #(
	parameter N = 14
) (
	input  wire [N*`ALM_W-1:0] alarms,
	output reg  [N-1:0]        valid
);

	// soft alarm alone never disqualifies an input
	function judge;
		input [`ALM_W-1:0] a;
		begin
			judge = ~(a[`ALM_HARD] | a[`ALM_ACT] | a[`ALM_LOCK]); // see [RULE1]
		end
	endfunction

	integer i;
	// one flag per input, one meaning valid
	always @* begin
		valid = {N{1'b0}};
		for (i = 0; i < N; i = i + 1) begin
			valid[i] = judge(alarms[i*`ALM_W +: `ALM_W]); // see [RULE4]
		end
	end

endmodule

// File: hw/change_detect.v
// flags any bit that changed since the previous cycle
module change_detect #(
	parameter W = 14
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire [W-1:0] din,
	output reg  [W-1:0] prev,
	output wire [W-1:0] changed
);

	// history register, cleared to all invalid
	always @(posedge clk) begin
		if (!resetn) begin
			prev <= {W{1'b0}};
		end else begin
			prev <= din;
		end
	end

	assign changed = din ^ prev;

endmodule

// File: hw/reference_validity_status.v
`include "valid_defs.vh"

// Overview of operation
// [RULE1] An input is valid with no alarm at all or with only a soft frequency alarm.
// [RULE2] The low byte holds inputs one to eight, input one at bit zero.
// [RULE3] The high byte holds inputs nine to fourteen at bits zero to five, top two bits unused.
// [RULE4] A flag reads one for a valid input and zero for an invalid one.
// [RULE5] Unused high bits read zero and writes to either status byte do nothing.
module reference_validity_status #(
	parameter N_INPUTS = 14
) (
	input  wire                       clk,
	input  wire                       resetn,
	input  wire [N_INPUTS*`ALM_W-1:0] alarms,
	input  wire [3:0]                 addr,
	input  wire [7:0]                 wdata,
	input  wire                       wr,
	input  wire                       rd,
	output reg  [7:0]                 rdata,
	output reg  [N_INPUTS-1:0]        valid_out,
	output reg                        irq
);

	wire [N_INPUTS-1:0] valid_now;
	wire [N_INPUTS-1:0] valid_chg;
	reg  [7:0]          status_low_r;
	reg  [7:0]          status_high_r;
	reg  [7:0]          mask_r;
	reg  [7:0]          mask_nxt;
	reg  [7:0]          irq_stat_r;
	reg  [7:0]          irq_stat_nxt;
	reg  [7:0]          rdata_nxt;
	wire [7:0]          events;

	// evaluates each input's alarms
	valid_eval #(
		.N(N_INPUTS)
	) u_eval (
		.alarms(alarms),
		.valid (valid_now)
	);

	// notices flag transitions for the interrupt
	change_detect #(
		.W(N_INPUTS)
	) u_chg (
		.clk    (clk),
		.resetn (resetn),
		.din    (valid_now),
		.prev   (),
		.changed(valid_chg)
	);

	// status bytes are snapshots of the live flags; no write path reaches them
	always @(posedge clk) begin
		if (!resetn) begin
			status_low_r  <= `VALID_RST;
			status_high_r <= `VALID_RST;
			valid_out     <= {N_INPUTS{1'b0}};
		end else begin
			status_low_r  <= valid_now[7:0]; // see [RULE2]
			status_high_r <= {2'b00, valid_now[N_INPUTS-1:8]}; // see [RULE3] see [RULE5]
			valid_out     <= valid_now;
		end
	end

	// event 0: any low input changed, event 1: any high input changed
	assign events = {6'h00, |valid_chg[N_INPUTS-1:8], |valid_chg[7:0]};

	// sticky status cleared by read; a fresh event beats the clear
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (rd && addr == `OFF_IRQ_STATUS) begin
			irq_stat_nxt = 8'h00;
		end
		irq_stat_nxt = irq_stat_nxt | events;
	end

	// mask next value, so irq tracks status and mask with no extra cycle of lag
	always @* begin
		mask_nxt = mask_r;
		if (wr && addr == `OFF_IRQ_MASK) begin // see [RULE5]
			mask_nxt = wdata;
		end
	end

	// read mux; unmapped offsets answer zero
	always @* begin
		case (addr)
		`OFF_VALID_LOW: begin
			rdata_nxt = status_low_r;
		end
		`OFF_VALID_HIGH: begin
			rdata_nxt = status_high_r;
		end
		`OFF_IRQ_STATUS: begin
			rdata_nxt = irq_stat_r;
		end
		`OFF_IRQ_MASK: begin
			rdata_nxt = mask_r;
		end
		default: begin
			rdata_nxt = 8'h00;
		end
		endcase
	end

	// bus side: only the mask is writable, status bytes ignore writes
	always @(posedge clk) begin
		if (!resetn) begin
			mask_r     <= `MASK_RST;
			irq_stat_r <= 8'h00;
			rdata      <= 8'h00;
			irq        <= 1'b0;
		end else begin
			mask_r     <= mask_nxt;
			irq_stat_r <= irq_stat_nxt;
			rdata      <= rd ? rdata_nxt : 8'h00;
			irq        <= |(irq_stat_nxt & mask_nxt);
		end
	end

endmodule

// File: testbench/rvs_chk.sv
module rvs_chk #(
	parameter N_INPUTS = 14
) (
	input logic                  clk,
	input logic                  resetn,
	input logic                  wr,
	input logic                  rd,
	input logic                  irq,
	input logic [N_INPUTS*4-1:0] alarms,
	input logic [3:0]            addr,
	input logic [7:0]            rdata,
	input logic [N_INPUTS-1:0]   valid_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// expected flags: hard, no-activity and lock alarms disqualify, soft alone does not
	function automatic [N_INPUTS-1:0] judge_all(input [N_INPUTS*4-1:0] x);
		for (int k = 0; k < N_INPUTS; k++) judge_all[k] = ~|x[4*k+1+:3];
	endfunction

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// flags follow the alarm words one cycle later
	property p_v; $past(resetn) |-> valid_out[0] == $past(~|alarms[3:1]); endproperty
	a_v: assert property (p_v) else $error("input one flag wrong");
	property p_all; $past(resetn) |-> valid_out == judge_all($past(alarms)); endproperty
	a_all: assert property (p_all) else $error("validity flags wrong");
	// read answers one cycle after the strobe, zero otherwise
	property p_l; rd && addr == 4'h0 |=> rdata == $past(valid_out[7:0]); endproperty
	a_l: assert property (p_l) else $error("low status byte wrong");
	property p_h; rd && addr == 4'h1 |=> rdata == $past(valid_out[13:8]); endproperty
	a_h: assert property (p_h) else $error("high status byte wrong");
	property p_w; wr |=> !rdata; endproperty
	a_w: assert property (p_w) else $error("write produced read data");
	property p_idle; !rd |=> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer cycle");

	// main scenarios
	cover property (rd && addr == 4'h1);
	cover property (irq);
	cover property (wr && addr < 4'h2);
	cover property (rd && addr == 4'h2 ##1 rdata != 8'h00);
endmodule

bind reference_validity_status rvs_chk #(
	.N_INPUTS(N_INPUTS)
) u_chk (
	.clk      (clk),
	.resetn   (resetn),
	.wr       (wr),
	.rd       (rd),
	.irq      (irq),
	.alarms   (alarms),
	.addr     (addr),
	.rdata    (rdata),
	.valid_out(valid_out)
);

// File: testbench/reference_validity_status_tb_top.sv
module reference_validity_status_tb_top;
	timeunit 1ns/1ns;
	logic        clk = 0;
	logic        resetn = 0;
	logic        wr = 0;
	logic        rd = 0;
	logic        irq;
	logic        q;
	logic [3:0]  addr = 0;
	logic [7:0]  wdata = 0;
	logic [7:0]  rdata;
	logic [7:0]  d;
	logic [7:0]  st;
	logic [13:0] valid_out;
	logic [13:0] e;
	logic [13:0] p = 0;
	logic [55:0] alarms = 0;
	logic [55:0] a;
	int          fails;
	int          samples_checked;
	reference_validity_status u_dut (
		.clk      (clk),
		.resetn   (resetn),
		.alarms   (alarms),
		.addr     (addr),
		.wdata    (wdata),
		.wr       (wr),
		.rd       (rd),
		.rdata    (rdata),
		.valid_out(valid_out),
		.irq      (irq)
	);
	// clock
	initial forever #25 clk=~clk;
	function automatic [13:0] ev(input [55:0] x);
		for(int k=0;k<14;k++) ev[k]=~|x[4*k+1+:3];
	endfunction
	task automatic ck(input [7:0] g,x);
		samples_checked++;
		fails+=g!==x;
		if(g!==x) $display("wrong value at %0t: got %h expected %h",$time,g,x);
	endtask
	task automatic acc(input w,input [3:0] ad,input [7:0] dt);
		{addr,wdata,wr,rd}<={ad,dt,w,!w};
		@(posedge clk);
		{wr,rd}<=0;
		// answer edge has passed: read data and irq are settled here
		#1;
		d=rdata;
		q=irq;
		@(posedge clk);
	endtask
	task automatic complete_run;
		$display("mismatches %0d, checks %0d",fails,samples_checked);
		if(fails==0&&samples_checked>0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// main
	initial begin
		void'($urandom(20));
		repeat(6) @(posedge clk);
		resetn<=1;
		for(int j=0;j<40;j++) begin
			for(int k=0;k<14;k++) a[4*k+:4]=j<4?1<<j:$urandom%(j%3?2:16);
			alarms<=a;
			e=ev(a);
			st={|(e[13:8]^p[13:8]),|(e[7:0]^p[7:0])};
			p=e;
			acc(1,3,j%4);
			acc(1,$urandom%3,$urandom);
			ck(q,|(st&j));
			acc(0,2,0);
			ck(d,st);
			acc(0,0,0);
			ck(d,e[7:0]);
			acc(0,1,0);
			ck(d,e[13:8]);
			acc(0,9,0);
			ck(d,0);
			$display("test %0d",j);
		end
		// every flag flips in the very cycle the status is read: the event must beat the clear
		for(int k=0;k<14;k++) a[4*k+:4]=p[k]?4'h2:4'h0;
		alarms<=a;
		e=ev(a);
		p=e;
		acc(0,2,0);
		ck(d,0);
		ck(q,1);
		acc(0,2,0);
		ck(d,8'h03);
		ck(q,0);
		$display("test event beats clear");
		// mid-run reset: outputs and registers return to zero, snapshot lags one cycle
		resetn<=1'b0;
		repeat(2) @(posedge clk);
		#1;
		ck(rdata,0);
		ck(irq,0);
		ck(valid_out[7:0],0);
		ck(valid_out[13:8],0);
		@(posedge clk);
		resetn<=1'b1;
		acc(0,0,0);
		ck(d,0);
		acc(0,0,0);
		ck(d,e[7:0]);
		acc(0,1,0);
		ck(d,e[13:8]);
		acc(0,2,0);
		ck(d,{|e[13:8],|e[7:0]});
		acc(0,3,0);
		ck(d,0);
		$display("test reset");
		complete_run;
	end
endmodule
